// ---- hw/sbxw_map.vh ----
// Constants for the shift, borrow, xor, wait and loop-end unit.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef SBXW_MAP_VH
`define SBXW_MAP_VH

// Opcodes
`define SBXW_OP_XOR 7'h07
`define SBXW_OP_SHR 7'h08
`define SBXW_OP_SHL 7'h09
`define SBXW_OP_WHILE 7'h27
`define SBXW_OP_WAIT 7'h30
`define SBXW_OP_SUBB 7'h4F

// Control register byte offsets (region 0)
`define SBXW_REG_CMD 8'h00
`define SBXW_REG_WMASK 8'h04
`define SBXW_REG_PRED 8'h08
`define SBXW_REG_STATUS 8'h0C
`define SBXW_REG_TCNT 8'h10
`define SBXW_REG_HCNT 8'h14
`define SBXW_REG_HNOTE 8'h18
`define SBXW_REG_IP 8'h1C
`define SBXW_REG_JIP 8'h20

// Address regions, addr[10:8]
`define SBXW_RGN_CTRL 3'h0
`define SBXW_RGN_SRC0 3'h1
`define SBXW_RGN_SRC1 3'h2
`define SBXW_RGN_DST 3'h3
`define SBXW_RGN_ACC 3'h4
`define SBXW_RGN_PER_CHANNEL_IP 3'h5

// Command register fields
`define SBXW_CMD_OP 6:0
`define SBXW_CMD_TYPE 9:8
`define SBXW_CMD_MOD0 11:10
`define SBXW_CMD_MOD1 13:12
`define SBXW_CMD_SAT 14
`define SBXW_CMD_NSEL 15
`define SBXW_CMD_SPF 16
`define SBXW_CMD_MASK 32'h0001FF7F

// Element types and source modifiers
`define SBXW_TYPE_B 2'h0
`define SBXW_TYPE_W 2'h1
`define SBXW_MOD_ABS 2'h1
`define SBXW_MOD_NEG 2'h2
`define SBXW_MOD_NABS 2'h3

// Misc values
`define SBXW_CNT_BITS 4:0
`define SBXW_JIP_BITS 15:0
`define SBXW_BORROW 32'h00000001
`define SBXW_NO_BORROW 32'h00000000
`define SBXW_IP_STEP 32'h00000002
`define SBXW_IP_NEXT 32'h00000001
`define SBXW_RESP_OKAY 2'h0
`define SBXW_RESP_SLVERR 2'h2
`define SBXW_STRB_ALL 4'hF

`endif

// ---- hw/sbxw_bank.v ----
// Word bank: parallel per-entry write, registered read, flat view.
// Assumes one clock, synchronous active-low reset, clock enable.
`default_nettype none
module sbxw_bank #(
    parameter WORDS = 8,
    parameter WIDTH = 32,
    parameter IDXW = 6
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // Parallel write
    input wire [WORDS-1:0] we,
    input wire [WORDS*WIDTH-1:0] wdata,
    // Registered read
    input wire re,
    input wire [IDXW-1:0] rd_idx,
    output reg [WIDTH-1:0] rd_q,
    // Every entry at once
    output wire [WORDS*WIDTH-1:0] all_q
);
    reg [WIDTH-1:0] mem [0:WORDS-1];
    integer k;

    // One register per entry
    genvar g;
    generate
        for (g = 0; g < WORDS; g = g + 1) begin : ent
            always @(posedge aclk) begin
                if (!aresetn) begin
                    mem[g] <= {WIDTH{1'b0}};
                end else if (ce && we[g]) begin
                    mem[g] <= wdata[g*WIDTH +: WIDTH];
                end
            end
            assign all_q[g*WIDTH +: WIDTH] = mem[g];
        end
    endgenerate

    // Out-of-range index reads zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_q <= {WIDTH{1'b0}};
        end else if (ce && re) begin
            rd_q <= {WIDTH{1'b0}};
            for (k = 0; k < WORDS; k = k + 1) begin
                if (rd_idx == k[IDXW-1:0]) begin
                    rd_q <= mem[k];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- hw/sbxw_unit.v ----
// Execution unit for shl, shr, subb, xor, wait and while.
// Assumes an AXI4-Lite master on aclk and notify pulses on aclk.
//
// What this block does
// RQ1: shl shifts enabled channels of source 0 left, zero filled.
// RQ2: Shift count is the low five bits of source 1, unsigned.
// RQ3: Left shift overflow detected and saturates when saturation set.
// RQ4: Stream must not target accumulator with shl; no packed sat.
// RQ5: shr shifts enabled channels right, inserting zeros at top.
// RQ6: shr ignores signedness of source and destination types.
// RQ7: subb writes source 0 minus source 1 per enabled channel.
// RQ8: subb writes borrow one or zero into the accumulator.
// RQ9: Stream sets accumulator write enable, never names accumulator.
// RQ10: wait on a zero counter suspends the thread.
// RQ11: wait on a nonzero counter decrements it and continues.
// RQ12: Notifications increment; a waiting thread wakes and decrements.
// RQ13: Thread counter fed by gateway port, host counter by register.
// RQ14: wait uses size one, no predicate, names a counter.
// RQ15: Two wait instructions never issue back to back.
// RQ16: while branches back when any channel is still live.
// RQ17: Jump offset is signed bits 15:0, added to pre-increment pointer.
// RQ18: Encoder supplies a signed, normally negative, jump offset.
// RQ19: Single flow mode freezes per-channel pointers, else updates them.
// RQ20: xor writes bitwise exclusive-or of both sources per channel.
// RQ21: Source modifiers apply to register sources before xor.
// RQ22: Stream attaches only zero or nonzero conditions to xor.
// RQ23: Disabled channels keep destination and accumulator unchanged.
`default_nettype none
`include "sbxw_map.vh"
module sbxw_unit #(
    parameter CHANNELS = 8
) (
    // Clock, reset, enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // Gateway notification pulse
    input wire thread_notify,
    // Thread state
    output reg thread_waiting,
    // AXI4-Lite write
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    localparam W = CHANNELS * 32;

    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg aw_held;
    reg w_held;
    reg [11:0] ar_addr;
    reg rd_stage;
    reg [31:0] cmd;
    reg [CHANNELS-1:0] channel_write_mask;
    reg [CHANNELS-1:0] pred;
    reg [31:0] ip;
    reg [15:0] loop_jump_offset;
    reg [31:0] thread_notify_counter;
    reg [31:0] host_notify_counter;
    reg exec_pend;
    reg branch_taken;
    reg any_ovf;
    reg bad_op;

    wire wr_do = aw_held && w_held && !s_axi_bvalid;
    wire [2:0] wr_rgn = aw_addr[10:8];
    wire [5:0] wr_idx = aw_addr[7:2];
    wire ctrl_wr = wr_do && wr_rgn == `SBXW_RGN_CTRL && aw_addr[11] == 1'b0;
    wire full_strb = w_strb == `SBXW_STRB_ALL;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire [6:0] opcode = cmd[`SBXW_CMD_OP];
    wire host_note = ctrl_wr && aw_addr[7:0] == `SBXW_REG_HNOTE && w_strb[0]
        && w_data[0];
    wire single_flow_mode = cmd[`SBXW_CMD_SPF];

    // Byte-lane merge for control registers
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // Element width mask from type field
    function [31:0] tmask;
        input [1:0] t;
        begin
            case (t)
                `SBXW_TYPE_B: tmask = 32'h000000FF;
                `SBXW_TYPE_W: tmask = 32'h0000FFFF;
                default: tmask = 32'hFFFFFFFF;
            endcase
        end
    endfunction

    // Numeric source modifier
    function [31:0] smod;
        input [31:0] s;
        input [1:0] m;
        reg [31:0] a;
        begin
            a = s[31] ? (32'h00000000 - s) : s;
            case (m)
                `SBXW_MOD_ABS: smod = a;
                `SBXW_MOD_NEG: smod = 32'h00000000 - s;
                `SBXW_MOD_NABS: smod = 32'h00000000 - a;
                default: smod = s;
            endcase
        end
    endfunction

    // Operand and result banks
    wire [W-1:0] src0_all;
    wire [W-1:0] src1_all;
    wire [W-1:0] dst_all;
    wire [W-1:0] acc_all;
    wire [W-1:0] per_channel_ip_all;
    wire [31:0] src0_q;
    wire [31:0] src1_q;
    wire [31:0] dst_q;
    wire [31:0] acc_q;
    wire [31:0] per_channel_ip_q;
    wire [CHANNELS-1:0] src0_we;
    wire [CHANNELS-1:0] src1_we;
    wire [CHANNELS-1:0] dst_we;
    wire [CHANNELS-1:0] acc_we;
    wire [CHANNELS-1:0] per_channel_ip_we;
    wire [W-1:0] dst_d;
    wire [W-1:0] acc_d;
    wire [W-1:0] per_channel_ip_d;
    wire [CHANNELS-1:0] lane_ovf;
    wire [CHANNELS-1:0] lane_live;
    wire [W-1:0] wdata_rep = {CHANNELS{w_data}};

    wire is_alu = opcode == `SBXW_OP_SHL || opcode == `SBXW_OP_SHR
        || opcode == `SBXW_OP_SUBB || opcode == `SBXW_OP_XOR;
    wire run_alu = exec_pend && is_alu;
    wire run_while = exec_pend && opcode == `SBXW_OP_WHILE;
    wire run_wait = exec_pend && opcode == `SBXW_OP_WAIT;
    wire [31:0] jip_ext = {{16{loop_jump_offset[15]}}, loop_jump_offset};
    wire [31:0] wcnt = cmd[`SBXW_CMD_NSEL] ? host_notify_counter
        : thread_notify_counter;

    // Per-channel datapath
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : lane
            wire [31:0] s0 = src0_all[g*32 +: 32];
            wire [31:0] s1 = src1_all[g*32 +: 32];
            wire [31:0] tm = tmask(cmd[`SBXW_CMD_TYPE]);
            wire [4:0] cnt = s1[`SBXW_CNT_BITS]; // [RQ2]
            wire [31:0] m0 = smod(s0, cmd[`SBXW_CMD_MOD0]) & tm; // [RQ21]
            wire [31:0] m1 = smod(s1, cmd[`SBXW_CMD_MOD1]) & tm; // [RQ21]
            wire [63:0] wide = {32'h00000000, m0} << cnt; // [RQ1]
            wire ovf = |(wide & ~{32'h00000000, tm}); // [RQ3]
            reg [31:0] res;
            // Unsigned saturation clamps to all ones of the element
            always @* begin
                case (opcode)
                    `SBXW_OP_SHL: res = (cmd[`SBXW_CMD_SAT] && ovf) ? tm
                        : wide[31:0] & tm; // [RQ1] [RQ3]
                    `SBXW_OP_SHR: res = m0 >> cnt; // [RQ5] [RQ6]
                    `SBXW_OP_SUBB: res = s0 - s1; // [RQ7]
                    default: res = m0 ^ m1; // [RQ20]
                endcase
            end
            assign dst_d[g*32 +: 32] = res;
            assign acc_d[g*32 +: 32] = (s0 < s1) ? `SBXW_BORROW
                : `SBXW_NO_BORROW; // [RQ8]
            assign lane_ovf[g] = ovf && opcode == `SBXW_OP_SHL
                && channel_write_mask[g];
            assign lane_live[g] = channel_write_mask[g] && pred[g]; // [RQ16]
            assign per_channel_ip_d[g*32 +: 32] = channel_write_mask[g]
                ? ip + jip_ext : ip + `SBXW_IP_NEXT; // [RQ19]
            assign src0_we[g] = wr_do && full_strb && !aw_addr[11]
                && wr_rgn == `SBXW_RGN_SRC0 && wr_idx == g;
            assign src1_we[g] = wr_do && full_strb && !aw_addr[11]
                && wr_rgn == `SBXW_RGN_SRC1 && wr_idx == g;
        end
    endgenerate

    // Only enabled channels write back results; loop end writes every pointer unless single flow mode, then none
    assign dst_we = run_alu ? channel_write_mask : {CHANNELS{1'b0}}; // [RQ23]
    assign acc_we = (run_alu && opcode == `SBXW_OP_SUBB)
        ? channel_write_mask : {CHANNELS{1'b0}}; // [RQ8] [RQ9] [RQ23]
    assign per_channel_ip_we = (run_while && !single_flow_mode)
        ? {CHANNELS{1'b1}} : {CHANNELS{1'b0}}; // [RQ19]

    sbxw_bank #(.WORDS(CHANNELS), .WIDTH(32), .IDXW(6)) u_src0 (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .we(src0_we),
        .wdata(wdata_rep), .re(ar_fire), .rd_idx(s_axi_araddr[7:2]),
        .rd_q(src0_q), .all_q(src0_all));
    sbxw_bank #(.WORDS(CHANNELS), .WIDTH(32), .IDXW(6)) u_src1 (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .we(src1_we),
        .wdata(wdata_rep), .re(ar_fire), .rd_idx(s_axi_araddr[7:2]),
        .rd_q(src1_q), .all_q(src1_all));
    sbxw_bank #(.WORDS(CHANNELS), .WIDTH(32), .IDXW(6)) u_dst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .we(dst_we),
        .wdata(dst_d), .re(ar_fire), .rd_idx(s_axi_araddr[7:2]),
        .rd_q(dst_q), .all_q(dst_all));
    sbxw_bank #(.WORDS(CHANNELS), .WIDTH(32), .IDXW(6)) u_acc (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .we(acc_we),
        .wdata(acc_d), .re(ar_fire), .rd_idx(s_axi_araddr[7:2]),
        .rd_q(acc_q), .all_q(acc_all));
    sbxw_bank #(.WORDS(CHANNELS), .WIDTH(32), .IDXW(6)) u_per_channel_ip (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .we(per_channel_ip_we),
        .wdata(per_channel_ip_d), .re(ar_fire), .rd_idx(s_axi_araddr[7:2]),
        .rd_q(per_channel_ip_q), .all_q(per_channel_ip_all));

    // Wait decrement at issue or on wake
    wire wait_pass = (run_wait || thread_waiting) && wcnt != 32'h00000000;
    wire dec_t = wait_pass && !cmd[`SBXW_CMD_NSEL]; // [RQ11] [RQ12]
    wire dec_h = wait_pass && cmd[`SBXW_CMD_NSEL]; // [RQ11] [RQ12]
    wire [31:0] next_tcnt = thread_notify_counter
        + {31'h00000000, thread_notify} - {31'h00000000, dec_t}; // [RQ13]
    wire [31:0] next_hcnt = host_notify_counter
        + {31'h00000000, host_note} - {31'h00000000, dec_h}; // [RQ13]
    wire [31:0] mask_m = merge({{(32-CHANNELS){1'b0}}, channel_write_mask},
        w_data, w_strb);
    wire [31:0] pred_m = merge({{(32-CHANNELS){1'b0}}, pred}, w_data,
        w_strb);
    wire [31:0] jip_m = merge({16'h0000, loop_jump_offset}, w_data, w_strb);

    // Issue, wait and loop end; commands refused while waiting
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= 32'h00000000;
            channel_write_mask <= {CHANNELS{1'b0}};
            pred <= {CHANNELS{1'b0}};
            ip <= 32'h00000000;
            loop_jump_offset <= 16'h0000;
            thread_notify_counter <= 32'h00000000;
            host_notify_counter <= 32'h00000000;
            exec_pend <= 1'b0;
            thread_waiting <= 1'b0;
            branch_taken <= 1'b0;
            any_ovf <= 1'b0;
            bad_op <= 1'b0;
        end else if (ce) begin
            thread_notify_counter <= next_tcnt; // [RQ12]
            host_notify_counter <= next_hcnt; // [RQ12]
            exec_pend <= 1'b0;
            if (ctrl_wr && !thread_waiting && !exec_pend) begin
                case (aw_addr[7:0])
                    `SBXW_REG_CMD: begin
                        cmd <= merge(cmd, w_data, w_strb) & `SBXW_CMD_MASK;
                        exec_pend <= 1'b1;
                    end
                    `SBXW_REG_WMASK: channel_write_mask <= mask_m[CHANNELS-1:0];
                    `SBXW_REG_PRED: pred <= pred_m[CHANNELS-1:0];
                    `SBXW_REG_IP: ip <= merge(ip, w_data, w_strb);
                    `SBXW_REG_JIP: loop_jump_offset <= jip_m[15:0]; // [RQ17]
                    default: ;
                endcase
            end
            if (run_alu) begin
                any_ovf <= |lane_ovf;
                ip <= ip + `SBXW_IP_STEP;
            end
            if (run_wait && wcnt == 32'h00000000) begin
                thread_waiting <= 1'b1; // [RQ10]
            end else if (wait_pass) begin
                thread_waiting <= 1'b0; // [RQ11] [RQ12]
                ip <= ip + `SBXW_IP_STEP;
            end
            if (run_while) begin
                branch_taken <= |lane_live;
                ip <= (|lane_live) ? ip + jip_ext
                    : ip + `SBXW_IP_STEP; // [RQ16] [RQ17]
            end
            if (exec_pend) begin
                bad_op <= !(is_alu || run_while || run_wait);
            end
        end
    end

    // Control read view; reserved bits zero
    reg [31:0] ctrl_rd;
    always @* begin
        case (ar_addr[7:0])
            `SBXW_REG_CMD: ctrl_rd = cmd;
            `SBXW_REG_WMASK: ctrl_rd = {{(32-CHANNELS){1'b0}},
                channel_write_mask};
            `SBXW_REG_PRED: ctrl_rd = {{(32-CHANNELS){1'b0}}, pred};
            `SBXW_REG_STATUS: ctrl_rd = {27'h0000000, exec_pend, bad_op,
                any_ovf, branch_taken, thread_waiting};
            `SBXW_REG_TCNT: ctrl_rd = thread_notify_counter;
            `SBXW_REG_HCNT: ctrl_rd = host_notify_counter;
            `SBXW_REG_IP: ctrl_rd = ip;
            `SBXW_REG_JIP: ctrl_rd = {16'h0000, loop_jump_offset}; // [RQ17]
            default: ctrl_rd = 32'h00000000;
        endcase
    end

    wire ctrl_ok = ar_addr[7:0] <= `SBXW_REG_JIP && ar_addr[1:0] == 2'h0;
    wire bank_ok = ar_addr[7:2] < CHANNELS;
    wire wctrl_ok = aw_addr[7:0] <= `SBXW_REG_JIP
        && aw_addr[1:0] == 2'h0;
    wire wbank_ok = wr_idx < CHANNELS && full_strb
        && (wr_rgn == `SBXW_RGN_SRC0 || wr_rgn == `SBXW_RGN_SRC1);
    wire wr_ok = !aw_addr[11] && (wr_rgn == `SBXW_RGN_CTRL ? wctrl_ok
        : wbank_ok);

    // AXI4-Lite write channel: address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SBXW_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `SBXW_RESP_OKAY : `SBXW_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read: banks are registered, answer a cycle later
    always @(posedge aclk) begin
        if (!aresetn) begin
            ar_addr <= 12'h000;
            rd_stage <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SBXW_RESP_OKAY;
        end else if (ce) begin
            if (ar_fire) begin
                ar_addr <= s_axi_araddr;
                s_axi_arready <= 1'b0;
                rd_stage <= 1'b1;
            end
            if (rd_stage) begin
                rd_stage <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `SBXW_RESP_SLVERR;
                s_axi_rdata <= 32'h00000000;
                if (!ar_addr[11]) begin
                    case (ar_addr[10:8])
                        `SBXW_RGN_CTRL: if (ctrl_ok) begin
                            s_axi_rdata <= ctrl_rd;
                            s_axi_rresp <= `SBXW_RESP_OKAY;
                        end
                        `SBXW_RGN_SRC0: if (bank_ok) begin
                            s_axi_rdata <= src0_q;
                            s_axi_rresp <= `SBXW_RESP_OKAY;
                        end
                        `SBXW_RGN_SRC1: if (bank_ok) begin
                            s_axi_rdata <= src1_q;
                            s_axi_rresp <= `SBXW_RESP_OKAY;
                        end
                        `SBXW_RGN_DST: if (bank_ok) begin
                            s_axi_rdata <= dst_q;
                            s_axi_rresp <= `SBXW_RESP_OKAY;
                        end
                        `SBXW_RGN_ACC: if (bank_ok) begin
                            s_axi_rdata <= acc_q;
                            s_axi_rresp <= `SBXW_RESP_OKAY;
                        end
                        `SBXW_RGN_PER_CHANNEL_IP: if (bank_ok) begin
                            s_axi_rdata <= per_channel_ip_q;
                            s_axi_rresp <= `SBXW_RESP_OKAY;
                        end
                        default: ;
                    endcase
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/sbxw_properties.sv ----
// Assertions for sbxw_unit.
// Assumes ce held high.
`default_nettype none
module sbxw_properties (
    // Clock, reset and thread state
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic thread_notify,
    input wire logic thread_waiting,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers hold until taken
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=>
        !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read late");
    chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready in read");
    chk_w_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("no write answer");
    // Refused reads carry no data
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
        |-> s_axi_rdata == 32'h0) else $error("error with data");
    // Sleep and wake have causes
    chk_wait_cause: assert property ($rose(thread_waiting) |->
        $past(s_axi_bvalid)) else $error("sleep uncaused");
    chk_wake_cause: assert property ($fell(thread_waiting) |->
        $past(thread_notify) || $past(thread_notify, 2) ||
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("wake uncaused");
endmodule
bind sbxw_unit sbxw_properties i_sbxw_properties (.*);
`default_nettype wire

// ---- verification/sbxw_notifier.sv ----
// Gateway model: one notify pulse per fire.
// Assumes fire is a one-cycle pulse on aclk.
`default_nettype none
module sbxw_notifier (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request and pulse
    input wire logic fire,
    output logic thread_notify = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] dly = 3'h0;
    // Late pulse lands on a sleeping thread
    always @(posedge aclk) begin
        dly <= aresetn ? {dly[1:0], fire} : 3'h0;
        thread_notify <= aresetn && dly[2];
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Bench for sbxw_unit: lanes, wait, loop end, errors.
// Assumes the bound checker and notifier model.
`default_nettype none
`include "sbxw_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, tn, thw;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic awr, wrd, bv, arr, rv;
    logic [1:0] br, rr;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0, rdq, m;
    logic [31:0] s0[8], s1[8], dst[8] = '{default: 32'h0};
    logic [31:0] acc[8] = '{default: 32'h0};
    logic [6:0] ops[4] = '{`SBXW_OP_SHL, `SBXW_OP_SHR, `SBXW_OP_XOR,
        `SBXW_OP_SUBB};
    logic [33:0] qr[$];
    logic [1:0] qb[$];
    int n_errors = 0, checked = 0, cyc = 0;
    always #25 aclk = ~aclk;
    sbxw_notifier i_sbxw_notifier (.aclk(aclk), .aresetn(aresetn),
        .fire(fire), .thread_notify(tn));
    sbxw_unit i_sbxw_unit (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .thread_notify(tn), .thread_waiting(thw), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdq), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre));
    task chk(string nm, logic [33:0] seen, logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [11:0] ad(logic [2:0] g, int i);
        return {1'b0, g, i[5:0], 2'b00};
    endfunction
    task wr(logic [11:0] a, logic [31:0] d, logic [1:0] e = 2'h0);
        @(posedge aclk);
        qb.push_back(e);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
    endtask
    task rd(logic [11:0] a, logic [31:0] d, logic [1:0] e = 2'h0);
        @(posedge aclk);
        qr.push_back({e, d});
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rre <= 1'b0;
    endtask
    task go(logic [6:0] op, logic [31:0] f = 32'h0);
        wr(`SBXW_REG_CMD, f | {25'h0, op});
    endtask
    // Oldest note meets each answer; ceiling cuts hangs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            test_done;
        end
        if (rv === 1'b1 && rre === 1'b1) chk("rd", {rr, rdq}, qr.pop_front());
        if (bv === 1'b1 && bre === 1'b1) chk("b", br, qb.pop_front());
    end
    initial begin
        void'($urandom(32'he673));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // Doubleword ops; lanes 0 and 1 get edge counts
        foreach (ops[k]) begin
            m = $urandom;
            for (int i = 0; i < 8; i++) begin
                s0[i] = $urandom;
                s1[i] = i == 0 ? 32'hFFFFFFE0 : i == 1 ? 32'h1F : $urandom;
                wr(ad(`SBXW_RGN_SRC0, i), s0[i]);
                wr(ad(`SBXW_RGN_SRC1, i), s1[i]);
            end
            wr(`SBXW_REG_WMASK, m);
            go(ops[k], 32'h200);
            for (int i = 0; i < 8; i++) begin
                if (m[i]) case (ops[k])
                    `SBXW_OP_SHL: dst[i] = s0[i] << s1[i][4:0];
                    `SBXW_OP_SHR: dst[i] = s0[i] >> s1[i][4:0];
                    `SBXW_OP_XOR: dst[i] = s0[i] ^ s1[i];
                    default: begin
                        dst[i] = s0[i] - s1[i];
                        acc[i] = {31'h0, s0[i] < s1[i]};
                    end
                endcase
                rd(ad(`SBXW_RGN_DST, i), dst[i]);
                rd(ad(`SBXW_RGN_ACC, i), acc[i]);
            end
        end
        // Host notice passes a wait; empty counter sleeps
        wr(`SBXW_REG_HNOTE, 32'h1);
        rd(`SBXW_REG_HCNT, 32'h1);
        go(`SBXW_OP_WAIT, 32'h8000);
        rd(`SBXW_REG_HCNT, 32'h0);
        chk("wait", thw, 34'h0);
        go(7'h00);
        go(`SBXW_OP_WAIT);
        repeat (2) @(posedge aclk);
        chk("wait", thw, 34'h1);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        for (int t = 0; t < 20 && thw !== 1'b0; t++) @(posedge aclk);
        chk("wait", thw, 34'h0);
        rd(`SBXW_REG_TCNT, 32'h0);
        // Loop end taken, then not, single flow
        wr(`SBXW_REG_IP, 32'h40);
        wr(`SBXW_REG_JIP, 32'hFFFFFFFC);
        rd(`SBXW_REG_JIP, 32'hFFFC);
        wr(`SBXW_REG_WMASK, 32'h1);
        wr(`SBXW_REG_PRED, 32'h1);
        go(`SBXW_OP_WHILE);
        rd(`SBXW_REG_IP, 32'h3C);
        rd(ad(`SBXW_RGN_PER_CHANNEL_IP, 1), 32'h41);
        wr(`SBXW_REG_PRED, 32'h0);
        go(`SBXW_OP_WHILE, 32'h10000);
        rd(`SBXW_REG_IP, 32'h3E);
        rd(ad(`SBXW_RGN_PER_CHANNEL_IP, 1), 32'h41);
        // Refused accesses change nothing
        rd(12'h800, 32'h0, `SBXW_RESP_SLVERR);
        wr(ad(`SBXW_RGN_DST, 0), 32'h1, `SBXW_RESP_SLVERR);
        rd(ad(`SBXW_RGN_DST, 0), dst[0]);
        test_done;
    end
endmodule
`default_nettype wire
